// ### rtl/bit_sync_gain_pkg.sv
package bit_sync_gain_pkg;

    // register offsets on the configuration port
    localparam logic [5:0] BIT_SYNC_CONFIG_ADDR  = 6'h1a;
    localparam logic [5:0] GAIN_CONTROL_TWO_ADDR = 6'h1b;

    // bit_sync_config fields
    localparam int PRESYNC_INTEGRAL_MSB      = 7;
    localparam int PRESYNC_INTEGRAL_LSB      = 6;
    localparam int PRESYNC_PROPORTIONAL_MSB  = 5;
    localparam int PRESYNC_PROPORTIONAL_LSB  = 4;
    localparam int POSTSYNC_INTEGRAL_BIT     = 3;
    localparam int POSTSYNC_PROPORTIONAL_BIT = 2;
    localparam int RATE_CLAMP_MSB            = 1;
    localparam int RATE_CLAMP_LSB            = 0;

    // gain_control_two fields
    localparam int DIGITAL_CEILING_MSB       = 7;
    localparam int DIGITAL_CEILING_LSB       = 6;
    localparam int FRONT_END_CEILING_MSB     = 5;
    localparam int FRONT_END_CEILING_LSB     = 3;
    localparam int AMPLITUDE_GOAL_MSB        = 2;
    localparam int AMPLITUDE_GOAL_LSB        = 0;

    // reset values: pre ki 01, pre kp 10, post ki 1, post kp 1, clamp 00
    localparam logic [7:0] BIT_SYNC_CONFIG_RESET  = 8'h6c;
    // digital ceiling 00, front-end ceiling 000, amplitude goal 011
    localparam logic [7:0] GAIN_CONTROL_TWO_RESET = 8'h03;

    // rate clamp in units of 1/32 of the data rate (3.125 %)
    localparam logic [2:0] RATE_CLAMP_32NDS [4] = '{3'h0, 3'h1, 3'h2, 3'h4};

    // front-end ceiling reduction in tenths of a dB
    localparam logic [7:0] FRONT_END_CUT_TENTHS_DB [8] =
        '{8'h00, 8'h1a, 8'h3d, 8'h4a, 8'h5c, 8'h73, 8'h92, 8'hab};

    // averaged channel-filter amplitude goal in dB
    localparam logic [5:0] AMPLITUDE_GOAL_DB [8] =
        '{6'h18, 6'h1b, 6'h1e, 6'h21, 6'h24, 6'h26, 6'h28, 6'h2a};

    // post-sync integral gain when halved, in half-units of the base gain
    localparam logic [3:0] HALF_BASE_INTEGRAL = 4'h1;

endpackage

// ### rtl/bit_sync_and_gain_config.sv
// Operation
// RULE1: The two-bit pre-sync proportional field picks 1x to 4x the base proportional gain until sync.
// RULE2: The two-bit pre-sync integral field, reset 01, picks 1x to 4x the base integral gain before sync.
// RULE3: After sync one bit picks the integral gain: 0 keeps the pre-sync gain, 1 halves the base; reset 1.
// RULE4: After sync one bit picks the proportional gain: 0 keeps pre-sync, 1 uses the base; reset 1.
// RULE5: The two-bit clamp field limits rate offset to 0, 3.125, 6.25 or 12.5 percent; reset 0.
// RULE6: The two-bit digital ceiling field forbids its count of the highest digital gain steps; reset 0.
// RULE7: The three-bit front-end ceiling lowers the gain cap by 0 to 17.1 dB in eight steps; reset 0.
// RULE8: The three-bit goal field sets the amplitude target from 24 to 42 dB; reset 3.
// RULE9: Every field here is host readable and writable and reads back its last written value.
// RULE10: Decoded settings drive the loops continuously and follow a write at the next clock edge.
`timescale 1ns/10ps
module bit_sync_and_gain_config
    import bit_sync_gain_pkg::*;
#(
    parameter int DIGITAL_GAIN_STEPS = 8
)
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // configuration port from the serial interface decoder
    input  wire logic [5:0] cfg_addr,
    input  wire logic       cfg_write,
    input  wire logic [7:0] cfg_wdata,
    input  wire logic       cfg_read,
    output logic      [7:0] cfg_rdata,
    // receiver state
    input  wire logic       sync_detected,
    // clock-recovery loop settings
    output logic      [3:0] integral_gain_halves,
    output logic      [2:0] proportional_gain_mult,
    output logic      [2:0] rate_clamp_32nds,
    // gain-control loop settings
    output logic      [2:0] digital_gain_top_step,
    output logic      [7:0] front_end_cut_tenths_db,
    output logic      [5:0] amplitude_goal_db
);

    initial
    begin
        if (DIGITAL_GAIN_STEPS < 4 || DIGITAL_GAIN_STEPS > 8)
            $error("DIGITAL_GAIN_STEPS must lie between 4 and 8");
    end

    logic [7:0] bit_sync_config;
    logic [7:0] gain_control_two;

    wire        write_bit_sync  = cfg_write && (cfg_addr == BIT_SYNC_CONFIG_ADDR);
    wire        write_gain_two  = cfg_write && (cfg_addr == GAIN_CONTROL_TWO_ADDR);
    wire  [7:0] next_bit_sync   = write_bit_sync ? cfg_wdata : bit_sync_config;
    wire  [7:0] next_gain_two   = write_gain_two ? cfg_wdata : gain_control_two;

    // field views of the next values so outputs follow the write edge
    wire  [1:0] presync_integral_gain      =
        next_bit_sync[PRESYNC_INTEGRAL_MSB:PRESYNC_INTEGRAL_LSB];
    wire  [1:0] presync_proportional_gain  =
        next_bit_sync[PRESYNC_PROPORTIONAL_MSB:PRESYNC_PROPORTIONAL_LSB];
    wire        postsync_integral_gain     = next_bit_sync[POSTSYNC_INTEGRAL_BIT];
    wire        postsync_proportional_gain = next_bit_sync[POSTSYNC_PROPORTIONAL_BIT];
    wire  [1:0] rate_offset_clamp          = next_bit_sync[RATE_CLAMP_MSB:RATE_CLAMP_LSB];
    wire  [1:0] digital_gain_ceiling       =
        next_gain_two[DIGITAL_CEILING_MSB:DIGITAL_CEILING_LSB];
    wire  [2:0] front_end_gain_ceiling     =
        next_gain_two[FRONT_END_CEILING_MSB:FRONT_END_CEILING_LSB];
    wire  [2:0] amplitude_goal             =
        next_gain_two[AMPLITUDE_GOAL_MSB:AMPLITUDE_GOAL_LSB];

    // integral gain in half-units of the base: (code + 1) x base
    wire  [3:0] presync_integral_halves    = {1'b0, presync_integral_gain, 1'b0} + 4'h2; // RULE2
    wire  [2:0] presync_proportional_mult  = {1'b0, presync_proportional_gain} + 3'h1;   // RULE1

    wire  [3:0] next_integral_halves       =
        (sync_detected && postsync_integral_gain) ? HALF_BASE_INTEGRAL // RULE3
                                                  : presync_integral_halves;
    wire  [2:0] next_proportional_mult     =
        (sync_detected && postsync_proportional_gain) ? 3'h1 // RULE4
                                                      : presync_proportional_mult;

    wire  [2:0] top_step_index             = 3'(DIGITAL_GAIN_STEPS - 1);
    wire  [2:0] next_digital_top_step      = top_step_index - {1'b0, digital_gain_ceiling}; // RULE6

    wire        read_bit_sync   = cfg_addr == BIT_SYNC_CONFIG_ADDR;
    wire        read_gain_two   = cfg_addr == GAIN_CONTROL_TWO_ADDR;
    wire  [7:0] read_value      = read_bit_sync ? bit_sync_config :
                                  read_gain_two ? gain_control_two : 8'h00;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bit_sync_config  <= BIT_SYNC_CONFIG_RESET;
            gain_control_two <= GAIN_CONTROL_TWO_RESET;
        end
        else
        begin
            bit_sync_config  <= next_bit_sync;  // RULE9
            gain_control_two <= next_gain_two;  // RULE9
        end
    end

    // read data holds until the next read
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            cfg_rdata <= 8'h00;
        else if (cfg_read)
            cfg_rdata <= read_value; // RULE9
    end

    // reset values decode to pre ki 2x (4 halves), pre kp 3x, clamp 0, goal 33 dB
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            integral_gain_halves    <= 4'h4;
            proportional_gain_mult  <= 3'h3;
            rate_clamp_32nds        <= 3'h0;
            // top step follows the parameter, not the largest legal step count
            digital_gain_top_step   <= 3'(DIGITAL_GAIN_STEPS - 1);
            front_end_cut_tenths_db <= 8'h00;
            amplitude_goal_db       <= 6'h21;
        end
        else
        begin
            integral_gain_halves    <= next_integral_halves;                    // RULE10
            proportional_gain_mult  <= next_proportional_mult;                  // RULE10
            rate_clamp_32nds        <= RATE_CLAMP_32NDS[rate_offset_clamp];     // RULE5
            digital_gain_top_step   <= next_digital_top_step;                   // RULE10
            front_end_cut_tenths_db <= FRONT_END_CUT_TENTHS_DB[front_end_gain_ceiling]; // RULE7
            amplitude_goal_db       <= AMPLITUDE_GOAL_DB[amplitude_goal];       // RULE8
        end
    end

endmodule

// ### verification/bit_sync_gain_monitor.sv
`timescale 1ns/10ps
module bit_sync_gain_monitor
    import bit_sync_gain_pkg::*;
#(parameter int DIGITAL_GAIN_STEPS = 8)
(
    input wire logic       clk_sys, reset_n, cfg_write, cfg_read, sync_detected,
    input wire logic [5:0] cfg_addr, amplitude_goal_db,
    input wire logic [7:0] cfg_wdata, cfg_rdata, front_end_cut_tenths_db,
    input wire logic [3:0] integral_gain_halves,
    input wire logic [2:0] proportional_gain_mult, rate_clamp_32nds, digital_gain_top_step
);
    wire wr_bs = cfg_write && cfg_addr == BIT_SYNC_CONFIG_ADDR;
    wire wr_gc = cfg_write && cfg_addr == GAIN_CONTROL_TWO_ADDR;
    wire mapped = cfg_addr == BIT_SYNC_CONFIG_ADDR || cfg_addr == GAIN_CONTROL_TWO_ADDR;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_goal_follows: assert property (wr_gc |=>
        amplitude_goal_db == AMPLITUDE_GOAL_DB[$past(cfg_wdata[2:0])]) else $error("goal");
    a_front_cut: assert property (wr_gc |=>
        front_end_cut_tenths_db == FRONT_END_CUT_TENTHS_DB[$past(cfg_wdata[5:3])]) else $error("cut");
    a_top_step: assert property (wr_gc |=>
        digital_gain_top_step == 3'(DIGITAL_GAIN_STEPS - 1) - $past(cfg_wdata[7:6])) else $error("top");
    a_rate_clamp: assert property (wr_bs |=>
        rate_clamp_32nds == RATE_CLAMP_32NDS[$past(cfg_wdata[1:0])]) else $error("clamp");
    a_post_integral: assert property (wr_bs && sync_detected |=> integral_gain_halves ==
        ($past(cfg_wdata[3]) ? 4'h1 : {1'b0, $past(cfg_wdata[7:6]), 1'b0} + 4'h2)) else $error("ki");
    a_post_prop: assert property (wr_bs && sync_detected |=> proportional_gain_mult ==
        ($past(cfg_wdata[2]) ? 3'h1 : $past(cfg_wdata[5:4]) + 3'h1)) else $error("kp");
    a_pre_gains: assert property (wr_bs && !sync_detected |=>
        proportional_gain_mult == $past(cfg_wdata[5:4]) + 3'h1
        && integral_gain_halves == {1'b0, $past(cfg_wdata[7:6]), 1'b0} + 4'h2) else $error("pre");
    a_read_back: assert property (wr_gc ##1 (cfg_read && !cfg_write && $stable(cfg_addr)) |=>
        cfg_rdata == $past(cfg_wdata, 2)) else $error("readback");
    a_unmapped_zero: assert property (cfg_read && !mapped |=> cfg_rdata == 8'h00) else $error("unmapped");
    c_sync_write: cover property (wr_bs && sync_detected);
    c_read_bs: cover property (cfg_read && cfg_addr == BIT_SYNC_CONFIG_ADDR);
    c_write_gc: cover property (wr_gc);
endmodule
bind bit_sync_and_gain_config bit_sync_gain_monitor #(.DIGITAL_GAIN_STEPS(DIGITAL_GAIN_STEPS)) mon (.*);

// ### verification/testbench.sv
`timescale 1ns/10ps
module testbench;
    import bit_sync_gain_pkg::*;
    logic       clk_sys = 0, reset_n = 0, cfg_write = 0, cfg_read = 0, sync_detected = 0;
    logic [5:0] cfg_addr = 0, amplitude_goal_db;
    logic [7:0] cfg_wdata = 0, cfg_rdata, front_end_cut_tenths_db, bs, gc;
    logic [3:0] integral_gain_halves;
    logic [2:0] proportional_gain_mult, rate_clamp_32nds, digital_gain_top_step;
    logic [31:0] seed = 32'h181a;
    logic [7:0] cut [8] = '{0, 26, 61, 74, 92, 115, 146, 171};
    logic [7:0] goal [8] = '{24, 27, 30, 33, 36, 38, 40, 42};
    int         num_errors = 0, num_checks = 0;
    // six gain steps so the top-step decode is not the default
    bit_sync_and_gain_config #(.DIGITAL_GAIN_STEPS(6)) dut (.*);
    always #25 clk_sys = ~clk_sys;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        num_checks++;
        if (seen !== want)
        begin
            num_errors++;
            $display("FAIL %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic verify(input logic s);
        check(integral_gain_halves, s && bs[3] ? 8'h1 : {bs[7:6], 1'b0} + 8'h2);
        check(proportional_gain_mult, s && bs[2] ? 8'h1 : bs[5:4] + 8'h1);
        check(rate_clamp_32nds, bs[1:0] == 2'h3 ? 8'h4 : bs[1:0]);
        check(digital_gain_top_step, 8'h5 - gc[7:6]);
        check(front_end_cut_tenths_db, cut[gc[5:3]]);
        check(amplitude_goal_db, goal[gc[2:0]]);
    endtask
    // drives at a falling edge, updates the mirror at the rising one
    task automatic step(input logic w, r, input logic [5:0] a, input logic [7:0] d, input logic s);
        logic [7:0] rd;
        cfg_write = w;
        cfg_read = r;
        cfg_addr = a;
        cfg_wdata = d;
        sync_detected = s;
        @(posedge clk_sys);
        rd = a == 6'h1a ? bs : a == 6'h1b ? gc : 8'h00;
        if (w && a == 6'h1a) bs = d;
        if (w && a == 6'h1b) gc = d;
        @(negedge clk_sys);
        verify(s);
        if (r) check(cfg_rdata, rd);
    endtask
    task automatic rst();
        reset_n = 0;
        bs = 8'h6c;
        gc = 8'h03;
        repeat (6) @(negedge clk_sys);
        reset_n = 1;
        step(0, 1, 6'h1a, 8'h00, 0);
        step(0, 1, 6'h1b, 8'h00, 1);
        $display("reset test done");
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        rst();
        for (int i = 0; i < 8; i++)
            step(1, 1, 6'h1b, {i[1:0], i[2:0], i[2:0]}, 0);
        step(0, 1, 6'h1b, 8'h00, 0);
        for (int i = 0; i < 8; i++)
            step(1, 1, 6'h1a, {i[1:0], i[1:0], i[0], i[1], i[1:0]}, i[2]);
        step(1, 1, 6'h3b, 8'h5a, 1);
        $display("code test done");
        repeat (400)
        begin
            seed = xs(seed);
            step(seed[0], seed[1], {seed[7] & seed[6], 4'hd, seed[2]}, seed[15:8], seed[3]);
        end
        $display("random test done");
        rst();
        summarize();
    end
endmodule
